// >>> gps_regs.sv
/*
  Gigabit master/slave status, extended ability and link control
  registers of a copper transceiver, with their page-received and
  speed-optimize companions, the idle error counter and speed optimizer.
  Assumes a management port with one-cycle strobes, read data in the
  cycle after the read strobe, and status inputs synchronous to clk.
*/
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "gps_consts.svh"

module gps_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire gps_pkg::gps_addr_t reg_addr,
  input wire gps_pkg::gps_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output gps_pkg::gps_word_t reg_rdata,
  input wire logic soft_reset,
  input wire logic ms_config_fault,
  input wire logic ms_resolved_master,
  input wire logic local_rx_ok,
  input wire logic remote_rx_ok,
  input wire logic partner_gig_full_duplex_able,
  input wire logic partner_gig_half_duplex_able,
  input wire logic page_received,
  input wire logic rx_idle,
  input wire logic rx_symbol_error,
  input wire logic an_attempt_failed,
  input wire logic an_attempt_ok,
  input wire logic idle_error_rate_high,
  output logic [1:0] link_break_threshold,
  output logic link_break_enable,
  output logic link_fail,
  output logic power_opt_enable,
  output logic speed_downshift,
  output logic logic_reset,
  output logic idle_count_overflow
);
  import gps_pkg::*;

  gps_core_if core ();

  gps_word_t link_control;
  gps_word_t next_link_control;
  gps_word_t mode_control;
  gps_word_t next_mode_control;
  logic fault_flag;
  logic next_fault_flag;
  logic page_flag;
  logic next_page_flag;
  gps_word_t rdata;
  gps_word_t next_rdata;
  logic fail;
  logic next_fail;

  logic wr_link_ctrl;
  logic wr_mode_ctrl;
  logic rd_ms_stat;
  logic rd_an_exp;

  function automatic logic reg_hit(input gps_addr_t addr, input gps_addr_t ofs);
    reg_hit = (addr == ofs);
  endfunction

  function automatic gps_word_t masked_write(
    input gps_word_t old_value,
    input gps_word_t new_value,
    input gps_word_t mask
  );
    masked_write = (old_value & ~mask) | (new_value & mask);
  endfunction

  assign wr_link_ctrl = reg_wr && reg_hit(reg_addr, `GPS_OFS_LINK_CTRL);
  assign wr_mode_ctrl = reg_wr && reg_hit(reg_addr, `GPS_OFS_MODE_CTRL);
  assign rd_ms_stat = reg_rd && reg_hit(reg_addr, `GPS_OFS_MS_STAT);
  assign rd_an_exp = reg_rd && reg_hit(reg_addr, `GPS_OFS_AN_EXP);

  // control registers
  always_comb begin
    next_link_control = link_control;
    next_mode_control = mode_control;
    if (wr_link_ctrl) begin
      next_link_control = masked_write(link_control, reg_wdata, `GPS_LC_WMASK);
    end
    if (wr_mode_ctrl) begin
      next_mode_control = masked_write(mode_control, reg_wdata, `GPS_MC_WMASK);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link_control <= `GPS_LC_RESET;
      mode_control <= `GPS_MC_RESET;
    end else begin
      link_control <= next_link_control;
      mode_control <= next_mode_control;
    end
  end

  // latching-high flags, set beats clear on read
  always_comb begin
    next_fault_flag = fault_flag;
    next_page_flag = page_flag;
    if (rd_ms_stat) begin
      next_fault_flag = 1'b0;
    end
    if (ms_config_fault) begin
      next_fault_flag = 1'b1;
    end
    if (rd_an_exp) begin
      next_page_flag = 1'b0;
    end
    if (page_received) begin
      next_page_flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fault_flag <= 1'b0;
      page_flag <= 1'b0;
    end else begin
      fault_flag <= next_fault_flag;
      page_flag <= next_page_flag;
    end
  end

  // read data, valid only in the cycle after the strobe
  always_comb begin
    next_rdata = `GPS_WORD_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        `GPS_OFS_MS_STAT: begin
          next_rdata[`GPS_MS_FAULT_BIT] = fault_flag;
          next_rdata[`GPS_MS_MASTER_BIT] = ms_resolved_master;
          next_rdata[`GPS_MS_LRX_BIT] = local_rx_ok;
          next_rdata[`GPS_MS_RRX_BIT] = remote_rx_ok;
          next_rdata[`GPS_MS_LPFD_BIT] = partner_gig_full_duplex_able;
          next_rdata[`GPS_MS_LPHD_BIT] = partner_gig_half_duplex_able;
          next_rdata[`GPS_MS_CNT_HI:`GPS_MS_CNT_LO] = core.idle_count;
        end
        `GPS_OFS_AN_EXP: begin
          next_rdata[`GPS_EXP_PAGE_BIT] = page_flag;
        end
        `GPS_OFS_EXT_STAT: begin
          next_rdata = `GPS_EXT_STAT_VALUE;
        end
        `GPS_OFS_LINK_CTRL: begin
          next_rdata = link_control & `GPS_LC_WMASK;
        end
        `GPS_OFS_MODE_CTRL: begin
          next_rdata = mode_control & `GPS_MC_WMASK;
        end
        default: begin
          next_rdata = `GPS_WORD_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= `GPS_WORD_ZERO;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign reg_rdata = rdata;

  // link break decision, held off while logic is in reset
  always_comb begin
    next_fail = 1'b0;
    if (link_control[`GPS_LC_LB_EN_BIT] && !link_control[`GPS_LC_LOGIC_RESET_BIT_BIT]) begin
      next_fail = idle_error_rate_high;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fail <= 1'b0;
    end else begin
      fail <= next_fail;
    end
  end

  // idle error counter hookup
  // count errors seen during idles
  assign core.idle_err = rx_idle && rx_symbol_error;
  // clear on read of the status word
  assign core.cnt_clr_rd = rd_ms_stat;
  // clear on hardware, software and logic reset
  assign core.cnt_clr_rst = soft_reset || link_control[`GPS_LC_LOGIC_RESET_BIT_BIT];

  // speed optimizer hookup
  // runs only with the enable bit
  assign core.so_en = mode_control[`GPS_MC_SO_EN_BIT];
  assign core.so_code = link_control[`GPS_LC_SO_HI:`GPS_LC_SO_LO];
  assign core.an_fail = an_attempt_failed;
  assign core.an_ok = an_attempt_ok;
  // logic reset clears internal state only
  assign core.so_clr = soft_reset || link_control[`GPS_LC_LOGIC_RESET_BIT_BIT];

  gps_idle_cnt u_idle_cnt (
    .clk (clk),
    .rst_n (rst_n),
    .cif (core)
  );

  gps_speed_opt u_speed_opt (
    .clk (clk),
    .rst_n (rst_n),
    .sif (core)
  );

  // threshold select to the error rate monitor
  assign link_break_threshold = link_control[`GPS_LC_LB_HI:`GPS_LC_LB_LO];
  assign link_break_enable = link_control[`GPS_LC_LB_EN_BIT];
  assign link_fail = fail;
  // power optimization active while bit is zero
  assign power_opt_enable = !link_control[`GPS_LC_PWR_DIS_BIT];
  assign speed_downshift = core.so_down;
  // held while software keeps bit 0 set
  assign logic_reset = link_control[`GPS_LC_LOGIC_RESET_BIT_BIT];
  // overflow event for the interrupt logic
  assign idle_count_overflow = core.idle_ovf;
endmodule

// >>> gps_consts.svh
/*
  Offsets, field positions, reset values and codes of the gigabit
  status / link control register bank.
  Assumes inclusion by bare name from each design file.
*/
`ifndef GPS_CONSTS_SVH
`define GPS_CONSTS_SVH

`define GPS_ADDR_W 5
`define GPS_DATA_W 16
`define GPS_CNT_W 8

`define GPS_OFS_AN_EXP 5'h06
`define GPS_OFS_MS_STAT 5'h0a
`define GPS_OFS_EXT_STAT 5'h0f
`define GPS_OFS_LINK_CTRL 5'h10
`define GPS_OFS_MODE_CTRL 5'h11

`define GPS_MS_FAULT_BIT 15
`define GPS_MS_MASTER_BIT 14
`define GPS_MS_LRX_BIT 13
`define GPS_MS_RRX_BIT 12
`define GPS_MS_LPFD_BIT 11
`define GPS_MS_LPHD_BIT 10
`define GPS_MS_CNT_HI 7
`define GPS_MS_CNT_LO 0

`define GPS_EXP_PAGE_BIT 1

`define GPS_EXT_STAT_VALUE 16'h3000

`define GPS_LC_SO_HI 9
`define GPS_LC_SO_LO 8
`define GPS_LC_LB_HI 5
`define GPS_LC_LB_LO 4
`define GPS_LC_LB_EN_BIT 3
`define GPS_LC_PWR_DIS_BIT 2
`define GPS_LC_LOGIC_RESET_BIT_BIT 0
`define GPS_LC_WMASK 16'h033d
`define GPS_LC_RESET 16'h0020

`define GPS_MC_SO_EN_BIT 7
`define GPS_MC_WMASK 16'h0080
`define GPS_MC_RESET 16'h0000

`define GPS_WORD_ZERO 16'h0000
`define GPS_CNT_ZERO 8'h00
`define GPS_CNT_MAX 8'hff
`define GPS_CNT_ONE 8'h01

`define GPS_ATT_ZERO 3'h0
`define GPS_ATT_ONE 3'h1
`define GPS_ATT_CODE0 3'h7
`define GPS_ATT_CODE1 3'h5
`define GPS_ATT_CODE2 3'h4
`define GPS_ATT_CODE3 3'h3

`endif

// >>> gps_pkg.sv
/*
  Types of the gigabit status / link control register bank.
  Assumes gps_consts.svh for the figures.
*/
`include "gps_consts.svh"

package gps_pkg;
  typedef logic [`GPS_ADDR_W-1:0] gps_addr_t;
  typedef logic [`GPS_DATA_W-1:0] gps_word_t;
  typedef logic [`GPS_CNT_W-1:0] gps_count_t;
  typedef logic [2:0] gps_attempt_t;
  typedef enum logic [1:0] {
    GPS_SO_IDLE,
    GPS_SO_COUNT,
    GPS_SO_DOWN
  } gps_so_state_t;
endpackage

// >>> gps_core_if.sv
/*
  Carrier between the register bank and its idle error counter and
  speed optimizer.
  Assumes all three sit on the same clock.
*/
`timescale 1ns/1ps

interface gps_core_if;
  import gps_pkg::*;
  logic idle_err;
  logic cnt_clr_rd;
  logic cnt_clr_rst;
  gps_count_t idle_count;
  logic idle_ovf;
  logic so_en;
  logic [1:0] so_code;
  logic an_fail;
  logic an_ok;
  logic so_clr;
  logic so_down;

  modport ctl (
    output idle_err, cnt_clr_rd, cnt_clr_rst, so_en, so_code, an_fail, an_ok, so_clr,
    input idle_count, idle_ovf, so_down
  );
  modport cnt (
    input idle_err, cnt_clr_rd, cnt_clr_rst,
    output idle_count, idle_ovf
  );
  modport spd (
    input so_en, so_code, an_fail, an_ok, so_clr,
    output so_down
  );
endinterface

// >>> gps_idle_cnt.sv
/*
  Saturating idle error counter, cleared on read and on any reset.
  Assumes one-cycle error, clear and read pulses on clk.
*/
`timescale 1ns/1ps
`include "gps_consts.svh"

module gps_idle_cnt (
  input wire logic clk,
  input wire logic rst_n,
  gps_core_if.cnt cif
);
  import gps_pkg::*;

  gps_count_t count;
  gps_count_t next_count;
  logic ovf;
  logic next_ovf;

  always_comb begin
    next_count = count;
    next_ovf = 1'b0;
    if (cif.cnt_clr_rst) begin
      next_count = `GPS_CNT_ZERO;
    end else if (cif.idle_err) begin
      if (count == `GPS_CNT_MAX) begin
        next_ovf = 1'b1;
        next_count = cif.cnt_clr_rd ? `GPS_CNT_ONE : `GPS_CNT_MAX;
      end else begin
        next_count = cif.cnt_clr_rd ? `GPS_CNT_ONE : gps_count_t'(count + `GPS_CNT_ONE);
      end
    end else if (cif.cnt_clr_rd) begin
      next_count = `GPS_CNT_ZERO;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= `GPS_CNT_ZERO;
      ovf <= 1'b0;
    end else begin
      count <= next_count;
      ovf <= next_ovf;
    end
  end

  assign cif.idle_count = count;
  assign cif.idle_ovf = ovf;
endmodule

// >>> gps_speed_opt.sv
/*
  Speed optimizer: counts failed negotiation attempts and asks for a
  lower advertised speed once the selected count is reached.
  Assumes one-cycle attempt result pulses on clk.
*/
`timescale 1ns/1ps
`include "gps_consts.svh"

module gps_speed_opt (
  input wire logic clk,
  input wire logic rst_n,
  gps_core_if.spd sif
);
  import gps_pkg::*;

  gps_so_state_t state;
  gps_so_state_t next_state;
  gps_attempt_t fails;
  gps_attempt_t next_fails;

  function automatic gps_attempt_t attempt_limit(input logic [1:0] code);
    case (code)
      2'h0: attempt_limit = `GPS_ATT_CODE0;
      2'h1: attempt_limit = `GPS_ATT_CODE1;
      2'h2: attempt_limit = `GPS_ATT_CODE2;
      default: attempt_limit = `GPS_ATT_CODE3;
    endcase
  endfunction

  always_comb begin
    next_state = state;
    next_fails = fails;
    case (state)
      GPS_SO_IDLE: begin
        next_fails = `GPS_ATT_ZERO;
        if (sif.so_en) begin
          next_state = GPS_SO_COUNT;
        end
      end
      GPS_SO_COUNT: begin
        if (!sif.so_en) begin
          next_state = GPS_SO_IDLE;
        end else if (sif.an_ok) begin
          next_fails = `GPS_ATT_ZERO;
        end else if (sif.an_fail) begin
          next_fails = gps_attempt_t'(fails + `GPS_ATT_ONE);
          if (next_fails >= attempt_limit(sif.so_code)) begin
            next_state = GPS_SO_DOWN;
          end
        end
      end
      GPS_SO_DOWN: begin
        if (!sif.so_en) begin
          next_state = GPS_SO_IDLE;
        end
      end
      default: next_state = GPS_SO_IDLE;
    endcase
    if (sif.so_clr) begin
      next_state = GPS_SO_IDLE;
      next_fails = `GPS_ATT_ZERO;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= GPS_SO_IDLE;
      fails <= `GPS_ATT_ZERO;
    end else begin
      state <= next_state;
      fails <= next_fails;
    end
  end

  assign sif.so_down = (state == GPS_SO_DOWN);
endmodule

// >>> gps_regs_properties.sv
/*
  Port checker of the gigabit status / link control register bank.
  Assumes it is bound to gps_regs and sees only its ports.
*/
`timescale 1ns/1ps

module gps_regs_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire gps_pkg::gps_addr_t reg_addr,
  input wire gps_pkg::gps_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire gps_pkg::gps_word_t reg_rdata,
  input wire logic soft_reset,
  input wire logic ms_config_fault,
  input wire logic ms_resolved_master,
  input wire logic local_rx_ok,
  input wire logic remote_rx_ok,
  input wire logic partner_gig_full_duplex_able,
  input wire logic partner_gig_half_duplex_able,
  input wire logic page_received,
  input wire logic rx_idle,
  input wire logic rx_symbol_error,
  input wire logic an_attempt_failed,
  input wire logic an_attempt_ok,
  input wire logic idle_error_rate_high,
  input wire logic [1:0] link_break_threshold,
  input wire logic link_break_enable,
  input wire logic link_fail,
  input wire logic power_opt_enable,
  input wire logic speed_downshift,
  input wire logic logic_reset,
  input wire logic idle_count_overflow
);
  import gps_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic wr_lc;
  logic rd_ms;
  assign wr_lc = reg_wr && reg_addr == 5'h10;
  assign rd_ms = reg_rd && reg_addr == 5'h0a;

  ext_value_a: assert property ($past(reg_rd && reg_addr == 5'h0f) |-> reg_rdata == 16'h3000)
    else $error("extended ability word wrong");
  unmapped_zero_a: assert property ($past(reg_rd && reg_addr == 5'h1f) |-> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  live_status_a: assert property ($past(rd_ms) |-> reg_rdata[14:8] == {$past(ms_resolved_master),
    $past(local_rx_ok), $past(remote_rx_ok), $past(partner_gig_full_duplex_able),
    $past(partner_gig_half_duplex_able), 2'b00}) else $error("status bits wrong");
  fault_latch_a: assert property ($past(ms_config_fault, 2) && $past(rd_ms) |-> reg_rdata[15])
    else $error("fault flag not latched");
  count_clear_a: assert property ($past(rd_ms) && $past(rd_ms, 3) && !$past(rx_symbol_error, 3)
    && !$past(rx_symbol_error, 2) |-> reg_rdata[7:0] == 8'h00) else $error("count not cleared");
  ctrl_write_a: assert property (wr_lc |=> {link_break_threshold, link_break_enable, logic_reset}
    == {$past(reg_wdata[5:3]), $past(reg_wdata[0])}) else $error("control outputs wrong");
  power_opt_a: assert property (wr_lc |=> power_opt_enable == !$past(reg_wdata[2]))
    else $error("power optimization wrong");
  logic_reset_bit_hold_a: assert property (!$past(wr_lc) |-> $stable(logic_reset))
    else $error("logic reset changed alone");
  link_fail_a: assert property (link_fail ==
    $past(link_break_enable && idle_error_rate_high && !logic_reset)) else $error("link fail wrong");
  overflow_a: assert property (idle_count_overflow |-> $past(rx_symbol_error && rx_idle))
    else $error("overflow without error");
  downshift_a: assert property ($rose(speed_downshift) |-> $past(an_attempt_failed))
    else $error("downshift without failed attempt");
endmodule

bind gps_regs gps_regs_chk chk_u (.*);

// >>> gps_mgmt_host.sv
/*
  Station management host model: one-cycle write and read strobes.
  Assumes read data stand in the cycle after the read strobe.
*/
`timescale 1ns/1ps

module gps_mgmt_host (
  input wire logic clk,
  output gps_pkg::gps_addr_t reg_addr,
  output gps_pkg::gps_word_t reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire gps_pkg::gps_word_t reg_rdata
);
  import gps_pkg::*;
  initial begin
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // released lines show the inverse, never the last value
  task automatic wr(input gps_addr_t a, input gps_word_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input gps_addr_t a, output gps_word_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
endmodule

// >>> tb_top.sv
/*
  Self-checking bench of the register bank.
  Assumes gps_mgmt_host drives the management port.
*/
`timescale 1ns/1ps

module tb_top;
  import gps_pkg::*;
  logic clk, rst_n, soft_reset, ms_config_fault, ms_resolved_master, local_rx_ok;
  logic remote_rx_ok, partner_gig_full_duplex_able, partner_gig_half_duplex_able;
  logic page_received, rx_idle, rx_symbol_error, an_attempt_failed, an_attempt_ok;
  logic idle_error_rate_high, reg_wr, reg_rd, link_break_enable, link_fail;
  logic power_opt_enable, speed_downshift, logic_reset, idle_count_overflow;
  logic [1:0] link_break_threshold;
  gps_addr_t reg_addr;
  gps_word_t reg_wdata, reg_rdata, rdv;
  int errors = 0;
  int checks_done = 0;
  int ovf_seen = 0;

  gps_regs dut_u (.*);
  gps_mgmt_host host_u (.*);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) if (idle_count_overflow === 1'b1) ovf_seen <= ovf_seen + 1;

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic errs(input int n, input logic idle);
    repeat (n) begin
      @(posedge clk);
      rx_idle <= idle;
      rx_symbol_error <= 1'b1;
      @(posedge clk);
      rx_symbol_error <= 1'b0;
    end
  endtask

  task automatic fails(input int n);
    repeat (n) begin
      @(posedge clk);
      an_attempt_failed <= 1'b1;
      @(posedge clk);
      an_attempt_failed <= 1'b0;
    end
  endtask

  task automatic t_reset_vals;
    check("thresh", 16'h0002, {14'h0, link_break_threshold});
    check("lb_en", 16'h0000, {15'h0, link_break_enable});
    check("pwr_opt", 16'h0001, {15'h0, power_opt_enable});
    host_u.rd(5'h10, rdv);
    check("link_ctrl", 16'h0020, rdv);
    host_u.rd(5'h0f, rdv);
    check("ext_stat", 16'h3000, rdv);
    host_u.rd(5'h1f, rdv);
    check("unmapped", 16'h0000, rdv);
  endtask

  task automatic t_link_ctrl;
    host_u.wr(5'h10, 16'hffff);
    host_u.rd(5'h10, rdv);
    check("lc_mask", 16'h033d, rdv);
    check("pwr_dis", 16'h0000, {15'h0, power_opt_enable});
    idle_error_rate_high <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check("logic_reset_bit_held", 16'h0001, {15'h0, logic_reset});
    check("fail_in_logic_reset_bit", 16'h0000, {15'h0, link_fail});
    for (int c = 0; c < 4; c++) begin
      host_u.wr(5'h10, 16'h0008 | 16'(c << 4));
      @(posedge clk);
      #1 check("thr_code", 16'(c), {14'h0, link_break_threshold});
      check("fail_on", 16'h0001, {15'h0, link_fail});
    end
    host_u.wr(5'h10, 16'h0000);
    repeat (2) @(posedge clk);
    #1 check("fail_off", 16'h0000, {15'h0, link_fail});
    idle_error_rate_high <= 1'b0;
  endtask

  task automatic t_status;
    {ms_resolved_master, local_rx_ok, remote_rx_ok} <= 3'b110;
    {partner_gig_full_duplex_able, partner_gig_half_duplex_able} <= 2'b10;
    ms_config_fault <= 1'b1;
    page_received <= 1'b1;
    @(posedge clk);
    ms_config_fault <= 1'b0;
    page_received <= 1'b0;
    host_u.wr(5'h0a, 16'hffff);
    // software looks at partner bits only once a page arrived
    host_u.rd(5'h06, rdv);
    check("page_rx", 16'h0002, rdv & 16'h0002);
    host_u.rd(5'h0a, rdv);
    check("ms_stat", 16'he800, rdv);
    {ms_resolved_master, local_rx_ok, remote_rx_ok} <= 3'b001;
    {partner_gig_full_duplex_able, partner_gig_half_duplex_able} <= 2'b01;
    host_u.rd(5'h0a, rdv);
    check("ms_stat2", 16'h1400, rdv);
  endtask

  task automatic t_counter;
    errs(3, 1'b1);
    errs(2, 1'b0);
    host_u.rd(5'h0a, rdv);
    check("cnt3", 16'h0003, rdv & 16'h00ff);
    host_u.rd(5'h0a, rdv);
    check("cnt_clr", 16'h0000, rdv & 16'h00ff);
    errs(258, 1'b1);
    host_u.rd(5'h0a, rdv);
    check("cnt_sat", 16'h00ff, rdv & 16'h00ff);
    check("ovf", 16'h0003, ovf_seen[15:0]);
    errs(4, 1'b1);
    host_u.wr(5'h10, 16'h0001);
    host_u.wr(5'h10, 16'h0000);
    host_u.rd(5'h0a, rdv);
    check("cnt_logic_reset_bit", 16'h0000, rdv & 16'h00ff);
    errs(4, 1'b1);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    host_u.rd(5'h0a, rdv);
    check("cnt_soft", 16'h0000, rdv & 16'h00ff);
  endtask

  task automatic t_speed;
    int lim;
    for (int c = 0; c < 4; c++) begin
      lim = (c == 0) ? 7 : 6 - c;
      host_u.wr(5'h10, 16'(c << 8));
      host_u.wr(5'h11, 16'h0080);
      repeat (2) @(posedge clk);
      fails(lim - 1);
      // a good attempt restarts the failure count
      @(posedge clk);
      an_attempt_ok <= 1'b1;
      @(posedge clk);
      an_attempt_ok <= 1'b0;
      fails(lim - 1);
      repeat (2) @(posedge clk);
      #1 check("no_shift", 16'h0000, {15'h0, speed_downshift});
      fails(1);
      @(posedge clk);
      #1 check("shift", 16'h0001, {15'h0, speed_downshift});
      host_u.wr(5'h11, 16'h0000);
    end
    fails(8);
    @(posedge clk);
    #1 check("shift_off", 16'h0000, {15'h0, speed_downshift});
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    {soft_reset, ms_config_fault, ms_resolved_master, local_rx_ok, remote_rx_ok} = '0;
    {partner_gig_full_duplex_able, partner_gig_half_duplex_able, page_received} = '0;
    {rx_idle, rx_symbol_error, an_attempt_failed, an_attempt_ok} = '0;
    idle_error_rate_high = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 t_reset_vals();
    t_link_ctrl();
    t_status();
    t_counter();
    t_speed();
    conclude();
  end
endmodule
